/* File: rtl/timed_io.sv */
// top of the timed io ports: apb registers, clock blocks, pin sharing
// assumes pins and strobes arrive asynchronously, one 100 MHz ref_clk
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module timed_io
    import tio_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [NPIN-1:0]  pin_i,
    output logic      [NPIN-1:0]  pin_o,
    output logic      [NPIN-1:0]  pin_oe,
    output logic      [NPIN-1:0]  pin_pd,
    input  wire logic [NPORT-1:0] strobe_in,
    output logic      [NPORT-1:0] strobe_out,
    output logic      [NPORT-1:0] sched_event
);
    logic [NPIN-1:0]  pin_s1_q;
    logic [NPIN-1:0]  pin_s2_q;
    logic [NPORT-1:0] stb_s1_q;
    logic [NPORT-1:0] stb_s2_q;
    logic             pin0_prev_q;
    logic             pin_rise;
    logic             pd_q;
    logic             link_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;
    port_ctrl_t       ctrl_q   [NPORT];
    logic [DW-1:0]    cond_q   [NPORT];
    cb_cfg_t          cb_q     [NCB];
    logic [NCB-1:0]   cb_tick;
    logic [NPORT-1:0] ptick;
    logic [DW-1:0]    po32     [NPORT];
    logic [DW-1:0]    xfer_a   [NPORT];
    port_stat_t       stat_a   [NPORT];
    port_flag_t       flag_a   [NPORT];
    logic [NPIN-1:0]  pin_o_c;
    logic [NPIN-1:0]  pin_oe_c;
    logic [NPIN-1:0]  od_pins;
    logic [31:0]      rd_c;
    logic             err_c;
    logic             setup;
    logic             wr_en;
    logic             rd_en;

    function automatic logic hit_port(input logic [11:0] a, input int p);
        return a[11:8] == PG_PORT && a[7:5] == 3'(p) && a[1:0] == 2'b00
            && a[4:2] <= R_FLAG;
    endfunction

    function automatic logic hit_cb(input logic [11:0] a, input int b);
        return a[11:8] == PG_CB && a[7:5] == 3'h0 && a[1:0] == 2'b00
            && a[4:2] == 3'(b);
    endfunction

    function automatic int cb_pick(input logic [2:0] sel);
        return (int'(sel) < NCB) ? int'(sel) : 0;
    endfunction

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign pready = 1'b1;

    // two flops on every pin and strobe before any logic reads them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            stb_s1_q <= '0;
            stb_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
            stb_s1_q <= strobe_in;
            stb_s2_q <= stb_s1_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin0_prev_q <= 1'b0;
        end else begin
            pin0_prev_q <= pin_s2_q[0];
        end
    end

    assign pin_rise = pin_s2_q[0] && !pin0_prev_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pd_q <= 1'b1;
        end else begin
            pd_q <= 1'b0;
        end
    end

    assign pin_pd = {NPIN{pd_q}};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link_q <= 1'b0;
        end else if (wr_en && paddr == {PG_LINK, 8'h00}) begin
            link_q <= pwdata[0];
        end
    end

    for (genvar b = 0; b < NCB; b++) begin : g_cb
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cb_q[b] <= CB_RST;
            end else if (wr_en && hit_cb(paddr, b)) begin
                cb_q[b] <= cb_cfg_t'(pwdata[8:0]);
            end
        end

        clock_block #(
            .IS_REF (b == 0)
        ) u_cb (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .cfg      (cb_q[b]),
            .pin_rise (pin_rise),
            .tick     (cb_tick[b])
        );
    end

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        localparam int W = port_width(p);
        logic [W-1:0] po;

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                ctrl_q[p] <= CTRL_RST;
                cond_q[p] <= '0;
            end else if (wr_en && hit_port(paddr, p)) begin
                if (paddr[4:2] == R_CTRL) begin
                    ctrl_q[p] <= port_ctrl_t'(pwdata[9:0]);
                end
                if (paddr[4:2] == R_COND) begin
                    cond_q[p] <= pwdata;
                end
            end
        end

        assign ptick[p] = cb_tick[cb_pick(ctrl_q[p].clk_sel)];

        timed_port #(
            .W (W)
        ) u_port (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .ctrl     (ctrl_q[p]),
            .tick     (ptick[p]),
            .pins_i   (pin_s2_q[W-1:0]),
            .strobe_i (stb_s2_q[p]),
            .wr_data  (wr_en && hit_port(paddr, p)
                       && paddr[4:2] == R_DATA),
            .rd_data  (rd_en && hit_port(paddr, p)
                       && paddr[4:2] == R_DATA),
            .wr_time  (wr_en && hit_port(paddr, p)
                       && paddr[4:2] == R_TIME),
            .wdata    (pwdata),
            .cond     (cond_q[p]),
            .pins_o   (po),
            .strobe_o (strobe_out[p]),
            .event_o  (sched_event[p]),
            .xfer     (xfer_a[p]),
            .stat     (stat_a[p]),
            .flag     (flag_a[p])
        );

        assign po32[p] = DW'(po);
    end

    // narrowest enabled port wins each pin, an enabled link wins over all ports on LINK_PINS (pins 4 to 7)
    always_comb begin
        logic found;
        found    = 1'b0;
        pin_o_c  = '0;
        pin_oe_c = '0;
        od_pins  = '0;
        for (int i = 0; i < NPIN; i++) begin
            found = 1'b0;
            for (int p = 0; p < NPORT; p++) begin
                if (!found && ctrl_q[p].enable && port_width(p) > i) begin
                    found = 1'b1;
                    if (ctrl_q[p].dir_out && ctrl_q[p].open_drain) begin
                        od_pins[i]  = 1'b1;
                        pin_oe_c[i] = !po32[p][i];
                    end else if (ctrl_q[p].dir_out) begin
                        pin_o_c[i]  = po32[p][i];
                        pin_oe_c[i] = 1'b1;
                    end
                end
            end
            if (link_q && LINK_PINS[i]) begin
                pin_o_c[i]  = 1'b0;
                pin_oe_c[i] = 1'b0;
            end
        end
    end

    assign pin_o  = pin_o_c;
    assign pin_oe = pin_oe_c;

    always_comb begin
        rd_c  = '0;
        err_c = 1'b1;
        if (paddr == {PG_LINK, 8'h00}) begin
            rd_c  = {31'h0, link_q};
            err_c = 1'b0;
        end
        for (int b = 0; b < NCB; b++) begin
            if (hit_cb(paddr, b)) begin
                rd_c  = {23'h0, cb_q[b]};
                err_c = 1'b0;
            end
        end
        for (int p = 0; p < NPORT; p++) begin
            if (hit_port(paddr, p)) begin
                err_c = 1'b0;
                unique case (paddr[4:2])
                    R_CTRL:  rd_c = {22'h0, ctrl_q[p]};
                    R_DATA:  rd_c = xfer_a[p];
                    R_COND:  rd_c = cond_q[p];
                    R_STAT:  rd_c = stat_a[p];
                    R_FLAG:  rd_c = {30'h0, flag_a[p]};
                    default: rd_c = '0;
                endcase
            end
        end
    end

    // read data and error are settled in the setup cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_c;
            pslverr_q <= err_c;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    logic [CW-1:0] cnt0;
    logic          busy1;
    logic          sel_any;
    assign cnt0    = stat_a[0].count;
    assign busy1   = flag_a[1].busy;
    assign sel_any = |{ctrl_q[0].clk_sel, ctrl_q[1].clk_sel,
                       ctrl_q[2].clk_sel, ctrl_q[3].clk_sel,
                       ctrl_q[4].clk_sel};

    a_apb_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        setup ##1 (psel && penable) |-> pready
            && prdata == $past(rd_c) || $past(pwrite))
        else $error("apb access not answered in one cycle");

    a_pd_released: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> pin_pd == '0)
        else $error("pull-downs still on after reset");

    a_link_pins_off: assert property (@(posedge ref_clk) disable iff (rst)
        link_q |-> (pin_oe & LINK_PINS) == '0)
        else $error("port drives a pin owned by the link");

    a_narrow_owns: assert property (@(posedge ref_clk) disable iff (rst)
        ctrl_q[0].enable && ctrl_q[0].dir_out && !ctrl_q[0].open_drain
        |-> pin_oe[0] && pin_o[0] == po32[0][0])
        else $error("1-bit port lost its pin");

    a_od_never_high: assert property (@(posedge ref_clk) disable iff (rst)
        (pin_o & od_pins) == '0)
        else $error("open drain pin driven high");

    a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
        ptick[0] |=> cnt0 == CW'($past(cnt0) + 1'b1))
        else $error("counter did not step on tick");

    a_ref_ticks: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> cb_tick[0])
        else $error("reference clock block missed a tick");

    a_reset_cb0: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst) |-> !sel_any)
        else $error("port not on clock block zero after reset");

    a_stamp_load: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(busy1) && ctrl_q[1].dir_out
        |-> stat_a[1].stamp == $past(stat_a[1].count))
        else $error("timestamp not taken at transfer");

    c_out_word: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(busy1) && ctrl_q[1].dir_out ##[1:64] !busy1);

    c_cond_event: cover property (@(posedge ref_clk) disable iff (rst)
        ctrl_q[1].cond_en && sched_event[1]);

    c_link_on: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(link_q));
endmodule

/* File: rtl/tio_pkg.sv */
// shared constants and carriers for the timed io ports and clock blocks
// assumes one 100 MHz reference clock and an apb register bus
package tio_pkg;
    localparam int NPORT   = 5;
    localparam int NCB     = 6;
    localparam int NPIN    = 32;
    localparam int DW      = 32;
    localparam int CW      = 16;
    localparam int CLK_MHZ = 100;
    localparam int REF_MHZ = 100;
    localparam int REF_DIV = CLK_MHZ / REF_MHZ;

    // address pages (paddr[11:8]) and word index inside a port window
    localparam logic [3:0]  PG_PORT   = 4'h0;
    localparam logic [3:0]  PG_CB     = 4'h1;
    localparam logic [3:0]  PG_LINK   = 4'h2;
    localparam logic [2:0]  R_CTRL    = 3'h0;
    localparam logic [2:0]  R_DATA    = 3'h1;
    localparam logic [2:0]  R_COND    = 3'h2;
    localparam logic [2:0]  R_TIME    = 3'h3;
    localparam logic [2:0]  R_STAT    = 3'h4;
    localparam logic [2:0]  R_FLAG    = 3'h5;
    localparam logic [31:0] LINK_PINS = 32'h0000_00f0;

    typedef struct packed {
        logic [2:0] clk_sel;
        logic       strobe_en;
        logic       cond_neq;
        logic       cond_en;
        logic       timed;
        logic       open_drain;
        logic       dir_out;
        logic       enable;
    } port_ctrl_t;

    typedef struct packed {
        logic [7:0] div;
        logic       src_pin;
    } cb_cfg_t;

    typedef struct packed {
        logic [CW-1:0] stamp;
        logic [CW-1:0] count;
    } port_stat_t;

    typedef struct packed {
        logic busy;
        logic valid;
    } port_flag_t;

    localparam port_ctrl_t CTRL_RST = '0;
    localparam cb_cfg_t    CB_RST   = '0;

    // port p has width 1, 4, 8, 16, 32
    function automatic int port_width(input int p);
        return (p == 0) ? 1 : (2 << p);
    endfunction
endpackage

/* File: rtl/clock_block.sv */
// one clock block: turns the reference clock or a pin edge into ticks
// assumes pin_rise is already synchronised to ref_clk
`timescale 1ns/1ps
module clock_block
    import tio_pkg::*;
#(
    parameter bit IS_REF = 1'b0
) (
    input  wire logic    ref_clk,
    input  wire logic    rst,
    input  wire cb_cfg_t cfg,
    input  wire logic    pin_rise,
    output logic         tick
);
    logic [7:0] div_q;
    logic       src_ev;
    logic       last;

    assign src_ev = (cfg.src_pin && !IS_REF) ? pin_rise : 1'b1;
    assign last   = IS_REF ? (div_q >= 8'(REF_DIV - 1))
                           : (div_q >= cfg.div);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (src_ev) begin
            div_q <= last ? '0 : 8'(div_q + 8'h01);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= src_ev && last;
        end
    end
endmodule

/* File: rtl/timed_port.sv */
// one timed port: counter, shift_serialiser, transfer register, condition
// assumes pins_i and strobe_i are synchronised and tick is a clock block
`timescale 1ns/1ps
module timed_port
    import tio_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire port_ctrl_t    ctrl,
    input  wire logic          tick,
    input  wire logic [W-1:0]  pins_i,
    input  wire logic          strobe_i,
    input  wire logic          wr_data,
    input  wire logic          rd_data,
    input  wire logic          wr_time,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [DW-1:0] cond,
    output logic [W-1:0]       pins_o,
    output logic               strobe_o,
    output logic               event_o,
    output logic [DW-1:0]      xfer,
    output port_stat_t         stat,
    output port_flag_t         flag
);
    localparam int N  = DW / W;
    localparam int LW = $clog2(N + 1);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} st_t;

    st_t           st_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] stamp_q;
    logic [CW-1:0] time_q;
    logic [DW-1:0] xfer_q;
    logic [DW-1:0] shift_serialiser_q;
    logic [LW-1:0] left_q;
    logic          full_q;
    logic          time_hit;
    logic          match;
    logic          load;
    logic          shout;
    logic          take;
    logic          done;
    logic [DW-1:0] shin;

    assign time_hit = !ctrl.timed || (count_q == time_q);
    assign match = ctrl.cond_neq ? (pins_i != cond[W-1:0])
                                 : (pins_i == cond[W-1:0]);
    assign shin  = (shift_serialiser_q >> W) | (DW'(pins_i) << (DW - W));
    assign load  = ctrl.enable && ctrl.dir_out && tick && left_q == '0
                && full_q && time_hit;
    assign shout = ctrl.enable && ctrl.dir_out && tick && left_q != '0;
    assign take  = ctrl.enable && !ctrl.dir_out && tick && st_q == ST_RUN
                && (!ctrl.strobe_en || strobe_i);
    assign done  = take && left_q == LW'(N - 1);

    // free running, wraps at the top
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            time_q <= '0;
        end else if (wr_time) begin
            time_q <= wdata[CW-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
        end else if (!ctrl.enable || ctrl.dir_out) begin
            st_q <= ST_IDLE;
        end else if (tick) begin
            unique case (st_q)
                ST_IDLE: begin
                    if (!full_q && time_hit) begin
                        st_q <= ctrl.cond_en ? ST_WAIT : ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (match) begin
                        st_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (done) begin
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // condition met or word captured reaches the scheduler one cycle later, through a flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            event_o <= 1'b0;
        end else begin
            event_o <= done || (ctrl.enable && !ctrl.dir_out && tick
                     && st_q == ST_WAIT && match);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shift_serialiser_q <= '0;
            left_q             <= '0;
            pins_o             <= '0;
        end else if (!ctrl.enable) begin
            left_q <= '0;
        end else if (load) begin
            shift_serialiser_q <= xfer_q >> W;
            left_q             <= LW'(N - 1);
            pins_o             <= xfer_q[W-1:0];
        end else if (shout) begin
            shift_serialiser_q <= shift_serialiser_q >> W;
            left_q             <= left_q - 1'b1;
            pins_o             <= shift_serialiser_q[W-1:0];
        end else if (take) begin
            shift_serialiser_q <= shin;
            left_q             <= done ? '0 : left_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobe_o <= 1'b0;
        end else begin
            strobe_o <= ctrl.strobe_en && (load || shout);
        end
    end

    // a capture in the same cycle as a read clear keeps the flag set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xfer_q  <= '0;
            full_q  <= 1'b0;
            stamp_q <= '0;
        end else if (done) begin
            xfer_q  <= shin;
            full_q  <= 1'b1;
            stamp_q <= count_q;
        end else if (load) begin
            full_q  <= 1'b0;
            stamp_q <= count_q;
        end else if (wr_data && ctrl.dir_out && !full_q) begin
            xfer_q <= wdata;
            full_q <= 1'b1;
        end else if (rd_data && !ctrl.dir_out) begin
            full_q <= 1'b0;
        end
    end

    assign xfer       = xfer_q;
    assign stat.stamp = stamp_q;
    assign stat.count = count_q;
    assign flag.busy  = left_q != '0 || st_q != ST_IDLE;
    assign flag.valid = full_q;
endmodule

/* File: tb/pin_partner.sv */
// external hardware on the pins: drives chosen pins, else pull or float
// assumes tio_pkg and the pin split of the timed io top
`timescale 1ns/1ps
module pin_partner
    import tio_pkg::*;
(
    input  wire logic [NPORT-1:0] stb_val,
    input  wire logic             ref_clk,
    input  wire logic [NPIN-1:0]  pin_o,
    input  wire logic [NPIN-1:0]  pin_oe,
    input  wire logic [NPIN-1:0]  pin_pd,
    input  wire logic [NPIN-1:0]  drv_val,
    input  wire logic [NPIN-1:0]  drv_en,
    output logic      [NPIN-1:0]  pin_i,
    output logic      [NPORT-1:0] strobe_in
);
    logic [NPIN-1:0] last_q;
    always_ff @(posedge ref_clk) begin
        last_q <= pin_i;
    end
    // an undriven pin without pull shows a changing level
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pin_oe[i])
                pin_i[i] = pin_o[i];
            else if (drv_en[i])
                pin_i[i] = drv_val[i];
            else if (pin_pd[i])
                pin_i[i] = 1'b0;
            else
                pin_i[i] = ~last_q[i];
        end
    end
    assign strobe_in = stb_val;
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the timed io top over apb and the pins
// assumes tio_pkg, timed_io and pin_partner
`timescale 1ns/1ps
module tb_top
    import tio_pkg::*;
();
    logic             ref_clk = 0, rst = 1, psel = 0, penable = 0;
    logic             pwrite = 0, pready, pslverr;
    logic [11:0]      paddr = '0;
    logic [31:0]      pwdata = '0, prdata, rv;
    logic [NPIN-1:0]  pin_i, pin_o, pin_oe, pin_pd;
    logic [NPIN-1:0]  drv_val = '0, drv_en = '0;
    logic [NPORT-1:0] strobe_in, strobe_out, sched_event;
    logic [NPORT-1:0] stb_val = '0;
    logic             ev;
    int               num_errors = 0, check_count = 0, cyc = 0, n;

    timed_io uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .pin_pd(pin_pd),
        .strobe_in(strobe_in), .strobe_out(strobe_out),
        .sched_event(sched_event));
    pin_partner far (.stb_val(stb_val), .ref_clk(ref_clk),
        .pin_o(pin_o), .pin_oe(pin_oe), .pin_pd(pin_pd), .drv_val(drv_val),
        .drv_en(drv_en), .pin_i(pin_i), .strobe_in(strobe_in));

    always #5 ref_clk = ~ref_clk;

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is seen high; release is left to rel
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rv = prdata;
        err = pslverr;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask

    task automatic rel();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    function automatic logic [3:0] nib(input logic od);
        return od ? ~pin_oe[3:0] : pin_o[3:0];
    endfunction

    task automatic out_run(input logic od);
        logic [31:0] d;
        logic [15:0] t;
        logic        e;
        d = $urandom();
        wr(12'h020, od ? 32'h0000_004f : 32'h0000_004b);
        apb(1'b0, 12'h030, '0, e);
        d[3:0] = nib(od) ^ 4'h5;
        t = 16'(rv + 32'd20);
        wr(12'h02c, {16'h0000, t});
        wr(12'h024, d);
        rel();
        n = 0;
        #1;
        while (nib(od) !== d[3:0] && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("first part", 32'(nib(od)), 32'(d[3:0]));
        chk("strobe out", 32'(strobe_out[1]), 32'h0000_0001);
        if (od)
            chk("od level", 32'(pin_o[3:0]), 32'h0000_0000);
        chk("oe outside", pin_oe & 32'hffff_fff0, 32'h0000_0000);
        for (int k = 1; k < 8; k++) begin
            @(posedge ref_clk);
            #1;
            chk("next part", 32'(nib(od)), 32'(d[4*k+:4]));
        end
        @(posedge ref_clk);
        #1;
        chk("strobe idle", 32'(strobe_out[1]), 32'h0000_0000);
        @(posedge ref_clk);
        apb(1'b0, 12'h030, '0, e);
        rel();
        chk("stamp", 32'(rv[31:16]), 32'(t));
        $display("output run od=%0b done", od);
    endtask

    initial begin
        logic [7:0]  v;
        logic [31:0] c1;
        logic        e;
        void'($urandom(36478));
        @(posedge ref_clk);
        #1;
        chk("pd in reset", pin_pd, 32'hffff_ffff);
        @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("pd after", pin_pd, 32'h0000_0000);
        @(posedge ref_clk);
        v = 8'($urandom());
        drv_val <= {24'h00_0000, v};
        drv_en <= 32'h0000_00ff;
        wr(12'h048, {24'h00_0000, v});
        wr(12'h040, 32'h0000_0051);
        rel();
        n = 0;
        repeat (30) begin
            @(posedge ref_clk);
            #1;
            ev = sched_event[2];
            n += int'(ev);
        end
        chk("held by strobe", n, 1);
        @(posedge ref_clk);
        stb_val <= 5'h04;
        repeat (30) begin
            @(posedge ref_clk);
            #1;
            ev = sched_event[2];
            n += int'(ev);
        end
        chk("events", n, 2);
        @(posedge ref_clk);
        apb(1'b0, 12'h044, '0, e);
        chk("captured word", rv, {4{v}});
        apb(1'b0, 12'h050, '0, e);
        c1 = rv;
        apb(1'b0, 12'h050, '0, e);
        rel();
        chk("count step", (rv - c1) & 32'h0000_ffff, 32'h0000_0002);
        drv_en <= '0;
        $display("input and counter done");
        out_run(1'b0);
        out_run(1'b1);
        wr(12'h020, 32'h0000_0003);
        wr(12'h040, 32'h0000_0003);
        rel();
        repeat (3) @(posedge ref_clk);
        chk("both own", pin_oe & 32'h0000_00ff, 32'h0000_00ff);
        wr(12'h200, 32'h0000_0001);
        rel();
        repeat (3) @(posedge ref_clk);
        chk("link takes", pin_oe & 32'h0000_00ff, 32'h0000_000f);
        wr(12'h020, 32'h0000_0001);
        rel();
        repeat (3) @(posedge ref_clk);
        chk("narrow input", pin_oe & 32'h0000_00ff, 32'h0000_0000);
        $display("sharing done");
        apb(1'b0, 12'h300, '0, e);
        chk("unmapped err", 32'(e), 32'h0000_0001);
        chk("unmapped data", rv, 32'h0000_0000);
        apb(1'b0, 12'h002, '0, e);
        rel();
        chk("misaligned err", 32'(e), 32'h0000_0001);
        $display("bus errors done");
        wr(12'h104, 32'h0000_0002);
        wr(12'h108, 32'h0000_0001);
        wr(12'h060, 32'h0000_0080);
        wr(12'h080, 32'h0000_0100);
        apb(1'b0, 12'h070, '0, e);
        c1 = rv;
        apb(1'b0, 12'h070, '0, e);
        chk("cb div", (rv - c1) & 32'h0000_ffff, 32'h0000_0001);
        apb(1'b0, 12'h090, '0, e);
        c1 = rv;
        apb(1'b0, 12'h090, '0, e);
        rel();
        chk("cb pin", (rv - c1) & 32'h0000_ffff, 32'h0000_0001);
        $display("clock blocks done");
        complete_run();
    end
endmodule
